// ---- rtl/traversing_block_pkg.sv ----
// Contract
// - sixteen independent block entries, index 0 to 15
// - block parameters latched at block change
// - mode bit 15: 0 block table, 1 direct
// - selector on mode word bits 0 to 3
// - selector value gives block number directly
// - control word bit 6 activates/deactivates task
// - task codes 1 to 9 decoded (code acts only on 1 and 6, other codes are passed on as stored)
// - four motion values stored per block
// - mode word: 0, type, continuation, identifiers
// - continuation 0: end, new edge required
// - continuation 1: stop in window, then advance
// - continuation 2: change at braking point
// - continuation 3: external edge or braking point
// - continuation 4: external edge, else hold
// - continuation 5: as 4, alarm at standstill
// - alarm may become fault cancelling sequence
// - positioning type only for task code 1
// - type 0 absolute, type 1 relative
// - types 2/3 modulo positive/negative direction
// - one task parameter per block
package traversing_block_pkg;
  localparam int CLK_KHZ       = 20000;
  localparam int IPO_PERIOD_US = 1000;
  localparam int IPO_CYCLES    = IPO_PERIOD_US * CLK_KHZ / 1000;
  localparam int NUM_BLOCKS    = 16;
  localparam int NUM_FIELDS    = 7;
  localparam logic [2:0] F_TASK   = 3'h0;
  localparam logic [2:0] F_TARGET = 3'h1;
  localparam logic [2:0] F_VEL    = 3'h2;
  localparam logic [2:0] F_ACCEL  = 3'h3;
  localparam logic [2:0] F_DECEL  = 3'h4;
  localparam logic [2:0] F_PARAM  = 3'h5;
  localparam logic [2:0] F_MODE   = 3'h6;
  localparam logic [11:0] TABLE_END   = 12'h200;
  localparam logic [11:0] CTRL_ADDR   = 12'h200;
  localparam logic [11:0] STATUS_ADDR = 12'h204;
  localparam int ST_ALARM  = 2;
  localparam int ST_FAULT  = 3;
  localparam int ST_DIRECT = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [3:0] {
    TASK_POSITION = 4'h1, TASK_HARD_STOP = 4'h2, TASK_ENDLESS_POS = 4'h3,
    TASK_ENDLESS_NEGATIVE = 4'h4, TASK_WAIT = 4'h5, TASK_GOTO = 4'h6,
    TASK_SET_OUT = 4'h7, TASK_RESET_OUT = 4'h8, TASK_JERK = 4'h9
  } task_t;
  typedef enum logic [3:0] {
    CONT_END = 4'h0, CONT_STOP = 4'h1, CONT_FLY = 4'h2,
    CONT_EXT = 4'h3, CONT_EXT_WAIT = 4'h4, CONT_EXT_ALARM = 4'h5
  } cont_t;
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} seq_t;
  typedef struct packed {
    logic [11:0] awaddr; logic awvalid; logic [31:0] wdata; logic [3:0] wstrb;
    logic wvalid; logic bready; logic [11:0] araddr; logic arvalid; logic rready;
  } axi_req_t;
  typedef struct packed {
    logic awready; logic wready; logic bvalid; logic [1:0] bresp;
    logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
  } axi_rsp_t;
  typedef struct packed {
    logic [3:0]  number;   logic [3:0] taskCode;
    logic [31:0] target;   logic [31:0] velocity;
    logic [31:0] accel;    logic [31:0] decel;
    logic [31:0] param;    logic [3:0] cont;
    logic [3:0]  posType;  logic hidden;
    logic relative; logic modPos; logic modNeg;
  } block_out_t;
endpackage

// ---- rtl/traversing_block_sequencer.sv ----
`timescale 1ns/1ps
module traversing_block_sequencer
  import traversing_block_pkg::*;
#(
  parameter int IPO_DIV = IPO_CYCLES
)
(
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire axi_req_t    axiIn,
  output axi_rsp_t         axiOut,
  input  wire logic [15:0] modeSelectWord,
  input  wire logic [15:0] controlWord1,
  input  wire logic        extBlockChange,
  input  wire logic        brakingPoint,
  input  wire logic        inPosWindow,
  input  wire logic        standstill,
  input  wire logic        reverseNeeded,
  output block_out_t       blockOut,
  output logic             blockStart,
  output logic             seqRunning,
  output logic             directMode,
  output logic             missingChangeAlarm,
  output logic             stopFault
);

  typedef struct packed {
    seq_t        seq;
    logic [31:0] ipoCnt;
    logic        actPrev;
    logic        extPrev;
    logic [3:0]  cur;
    block_out_t  blk;
    logic        blkStart;
    logic        running;
    logic        direct;
    logic        alarm;
    logic        fault;
    logic        alarmToFault;
    logic        awHeld;
    logic        wHeld;
    logic [11:0] awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    axi_rsp_t    rsp;
  } state_t;

  state_t      s;
  state_t      next_s;
  logic [31:0] tbl [0:NUM_BLOCKS-1][0:NUM_FIELDS-1];
  logic        tblWe;
  logic [3:0]  tblRow;
  logic [2:0]  tblCol;
  logic [31:0] tblData;
  logic        ipoTick;
  logic        actBit;
  logic        actRise;
  logic        extEdge;
  logic        atTarget;
  logic        advance;
  logic        finish;
  logic [3:0]  nextIdx;
  logic [31:0] wMerged;
  logic        alarmClr;
  logic        faultClr;

  function automatic logic [31:0] fieldMask(input logic [2:0] col);
    case (col)
      F_TASK:  fieldMask = 32'h0000000F;
      F_MODE:  fieldMask = 32'h0000FFFF;
      default: fieldMask = 32'hFFFFFFFF;
    endcase
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    merge = old;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
        merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction

  // a block is copied whole on entry so edits only act on the next entry
  function automatic block_out_t loadBlock(input logic [3:0] idx);
    logic [15:0] mode;
    mode = tbl[idx][F_MODE][15:0];
    loadBlock          = '0;
    loadBlock.number   = idx;
    loadBlock.taskCode = tbl[idx][F_TASK][3:0];
    loadBlock.target   = tbl[idx][F_TARGET];
    loadBlock.velocity = tbl[idx][F_VEL];
    loadBlock.accel    = tbl[idx][F_ACCEL];
    loadBlock.decel    = tbl[idx][F_DECEL];
    loadBlock.param    = tbl[idx][F_PARAM];
    loadBlock.hidden   = mode[0];
    loadBlock.cont     = mode[7:4];
    if (loadBlock.taskCode == TASK_POSITION)
    begin
      loadBlock.posType  = mode[11:8];
      loadBlock.relative = (mode[11:8] == 4'h1);
      loadBlock.modPos   = (mode[11:8] == 4'h2);
      loadBlock.modNeg   = (mode[11:8] == 4'h3);
    end
  endfunction

  function automatic logic [31:0] readMux(input logic [11:0] a);
    readMux = 32'h00000000;
    if (a < TABLE_END && a[4:2] != 3'h7)
      readMux = tbl[a[8:5]][a[4:2]] & fieldMask(a[4:2]);
    else if (a == CTRL_ADDR)
      readMux = {31'h0, s.alarmToFault};
    else if (a == STATUS_ADDR)
    begin
      readMux[1:0]       = s.seq;
      readMux[ST_ALARM]  = s.alarm;
      readMux[ST_FAULT]  = s.fault;
      readMux[ST_DIRECT] = s.direct;
      readMux[11:8]      = s.cur;
    end
  endfunction

  function automatic logic mapped(input logic [11:0] a);
    mapped = (a < TABLE_END && a[4:2] != 3'h7) || a == CTRL_ADDR || a == STATUS_ADDR;
  endfunction

  always_comb
  begin
    next_s   = s;
    tblWe    = 1'b0;
    tblRow   = s.awAddr[8:5];
    tblCol   = s.awAddr[4:2];
    wMerged  = 32'h00000000;
    tblData  = 32'h00000000;
    alarmClr = 1'b0;
    faultClr = 1'b0;
    advance  = 1'b0;
    finish   = 1'b0;
    nextIdx  = s.cur + 4'h1;
    next_s.blkStart = 1'b0;
    // one clock only: the interpolation rate is an enable pulse
    ipoTick = (s.ipoCnt == 32'(IPO_DIV - 1));
    next_s.ipoCnt = ipoTick ? 32'h0 : s.ipoCnt + 32'h1;
    actBit   = controlWord1[6];
    actRise  = actBit && !s.actPrev;
    extEdge  = extBlockChange && !s.extPrev;
    atTarget = inPosWindow && standstill;

    // register write side
    if (axiIn.awvalid && s.rsp.awready)
    begin
      next_s.awHeld = 1'b1;
      next_s.awAddr = axiIn.awaddr;
    end
    if (axiIn.wvalid && s.rsp.wready)
    begin
      next_s.wHeld = 1'b1;
      next_s.wData = axiIn.wdata;
      next_s.wStrb = axiIn.wstrb;
    end
    if (s.rsp.bvalid && axiIn.bready)
      next_s.rsp.bvalid = 1'b0;
    if (s.awHeld && s.wHeld && !s.rsp.bvalid)
    begin
      next_s.awHeld     = 1'b0;
      next_s.wHeld      = 1'b0;
      next_s.rsp.bvalid = 1'b1;
      next_s.rsp.bresp  = mapped(s.awAddr) ? RESP_OKAY : RESP_SLVERR;
      wMerged = merge(readMux(s.awAddr), s.wData, s.wStrb);
      if (s.awAddr < TABLE_END && s.awAddr[4:2] != 3'h7)
      begin
        tblWe   = 1'b1;
        tblData = wMerged & fieldMask(tblCol);
      end
      else if (s.awAddr == CTRL_ADDR)
        next_s.alarmToFault = wMerged[0];
      else if (s.awAddr == STATUS_ADDR && s.wStrb[0])
      begin
        alarmClr = s.wData[ST_ALARM];
        faultClr = s.wData[ST_FAULT];
      end
    end
    if (alarmClr)
      next_s.alarm = 1'b0;
    if (faultClr)
      next_s.fault = 1'b0;

    // register read side
    if (axiIn.arvalid && s.rsp.arready)
    begin
      next_s.rsp.arready = 1'b0;
      next_s.rsp.rvalid  = 1'b1;
      next_s.rsp.rdata   = readMux(axiIn.araddr);
      next_s.rsp.rresp   = mapped(axiIn.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rsp.rvalid && axiIn.rready)
    begin
      next_s.rsp.rvalid  = 1'b0;
      next_s.rsp.arready = 1'b1;
    end

    // sequencer, stepped once per interpolation cycle
    if (ipoTick)
    begin
      next_s.actPrev = actBit;
      next_s.extPrev = extBlockChange;
      next_s.direct  = modeSelectWord[15];
      case (s.seq)
        SEQ_IDLE:
        begin
          // fault must be acknowledged before a new start
          if (actRise && !modeSelectWord[15] && !s.fault)
          begin
            next_s.cur      = modeSelectWord[3:0];
            next_s.blk      = loadBlock(modeSelectWord[3:0]);
            next_s.blkStart = 1'b1;
            next_s.seq      = SEQ_RUN;
          end
        end
        SEQ_RUN:
        begin
          if (!actBit)
            next_s.seq = SEQ_IDLE;
          else if (s.blk.taskCode == TASK_GOTO)
          begin
            advance = 1'b1;
            nextIdx = s.blk.param[3:0];
          end
          else
          begin
            case (s.blk.cont)
              CONT_END:  finish  = atTarget;
              CONT_STOP: advance = atTarget;
              CONT_FLY:  advance = brakingPoint && (!reverseNeeded || atTarget);
              CONT_EXT:  advance = extEdge ||
                                   (brakingPoint && (!reverseNeeded || atTarget));
              CONT_EXT_WAIT: advance = extEdge;
              CONT_EXT_ALARM:
              begin
                advance = extEdge;
                if (!extEdge && standstill)
                begin
                  next_s.alarm = 1'b1;
                  if (s.alarmToFault)
                  begin
                    next_s.fault = 1'b1;
                    next_s.seq   = SEQ_IDLE;
                  end
                end
              end
              default: finish = atTarget;
            endcase
            // the last entry has no successor
            if (advance && s.cur == 4'hF)
            begin
              advance = 1'b0;
              finish  = 1'b1;
            end
          end
          if (advance)
          begin
            next_s.cur      = nextIdx;
            next_s.blk      = loadBlock(nextIdx);
            next_s.blkStart = 1'b1;
          end
          if (finish)
            next_s.seq = SEQ_DONE;
        end
        SEQ_DONE:
        begin
          if (!actBit)
            next_s.seq = SEQ_IDLE;
        end
        default: next_s.seq = SEQ_IDLE;
      endcase
    end
    next_s.running     = (next_s.seq == SEQ_RUN);
    next_s.rsp.awready = !next_s.awHeld && !next_s.rsp.bvalid;
    next_s.rsp.wready  = !next_s.wHeld && !next_s.rsp.bvalid;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      s <= '0;
      s.seq <= SEQ_IDLE;
      s.rsp.arready <= 1'b1;
    end
    else
      s <= next_s;
    if (tblWe)
      tbl[tblRow][tblCol] <= tblData;
  end

  assign axiOut             = s.rsp;
  assign blockOut           = s.blk;
  assign blockStart         = s.blkStart;
  assign seqRunning         = s.running;
  assign directMode         = s.direct;
  assign missingChangeAlarm = s.alarm;
  assign stopFault          = s.fault;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence runTick;
    s.seq == SEQ_RUN && ipoTick && controlWord1[6] && s.blk.taskCode != TASK_GOTO;
  endsequence

  sequence startReq;
    s.seq == SEQ_IDLE && ipoTick && actRise && !modeSelectWord[15] && !s.fault;
  endsequence

  sequence gotoTick;
    s.seq == SEQ_RUN && ipoTick && controlWord1[6] && s.blk.taskCode == TASK_GOTO;
  endsequence

  start_select_a: assert property (startReq |=> s.running ##0 s.blkStart
    ##0 s.cur == $past(modeSelectWord[3:0]))
    else $error("selected block not entered");

  latch_hold_a: assert property (!s.blkStart |-> $stable(s.blk))
    else $error("block data changed outside a block change");

  pos_gate_a: assert property (s.blk.taskCode != TASK_POSITION
    |-> s.blk.posType == 4'h0 && !s.blk.relative)
    else $error("positioning type used for non-positioning task");

  end_done_a: assert property (runTick ##0 s.blk.cont == CONT_END && atTarget
    |=> s.seq == SEQ_DONE ##1 !s.blkStart)
    else $error("end continuation did not stop sequence");

  wait_hold_a: assert property (runTick ##0 s.blk.cont == CONT_EXT_WAIT
    && !extEdge |=> !s.blkStart)
    else $error("block changed without external edge");

  fly_change_a: assert property (runTick ##0 s.blk.cont == CONT_FLY
    && brakingPoint && !reverseNeeded && s.cur != 4'hF
    |=> s.blkStart && s.cur == $past(s.cur) + 4'h1)
    else $error("no change at braking point");

  ext_edge_a: assert property (runTick ##0 s.blk.cont == CONT_EXT && extEdge
    && s.cur != 4'hF |=> s.blkStart)
    else $error("external edge ignored");

  alarm_raise_a: assert property (runTick ##0 s.blk.cont == CONT_EXT_ALARM
    && !extEdge && standstill |=> s.alarm)
    else $error("missing change alarm not raised");

  fault_cancel_a: assert property (runTick ##0 s.blk.cont == CONT_EXT_ALARM
    && !extEdge && standstill && s.alarmToFault |=> s.fault && s.seq == SEQ_IDLE)
    else $error("fault did not cancel sequence");

  deact_stop_a: assert property (s.seq == SEQ_RUN && ipoTick && !controlWord1[6]
    |=> s.seq == SEQ_IDLE && !s.running)
    else $error("deactivation ignored");

  write_resp_a: assert property (s.awHeld && s.wHeld && !s.rsp.bvalid
    |=> s.rsp.bvalid && !s.rsp.awready)
    else $error("write response missing");

  goto_jump_a: assert property (gotoTick |=> s.blkStart
    ##0 s.cur == $past(s.blk.param[3:0]))
    else $error("jump did not reach its target block");

  stop_wait_a: assert property (runTick ##0 s.blk.cont == CONT_STOP && !atTarget
    |=> !s.blkStart)
    else $error("block left before target reached");

  start_refuse_a: assert property (s.seq == SEQ_IDLE && ipoTick
    && (modeSelectWord[15] || s.fault) |=> !s.blkStart && !s.running)
    else $error("start taken in direct mode or under fault");

endmodule

// ---- verif/plc_controller_model.sv ----
`timescale 1ns/1ps
module plc_controller_model
(
  input  wire logic        clk,
  output logic [15:0]      modeSelectWord,
  output logic [15:0]      controlWord1,
  output logic             extBlockChange
);
  initial
  begin
    modeSelectWord = 16'h0000;
    controlWord1   = 16'h0000;
    extBlockChange = 1'b0;
  end
  // words only change after an edge, like a cyclic telegram update
  task automatic select(input logic direct, input logic [3:0] idx);
    @(posedge clk);
    modeSelectWord <= {direct, 11'h000, idx};
  endtask
  task automatic activate(input logic on);
    @(posedge clk);
    controlWord1 <= {9'h000, on, 6'h00};
  endtask
  task automatic ext_change(input logic lvl);
    @(posedge clk);
    extBlockChange <= lvl;
  endtask
endmodule

// ---- verif/traversing_block_sequencer_tb.sv ----
`timescale 1ns/1ps
module traversing_block_sequencer_tb;
  import traversing_block_pkg::*;
  localparam int IPO = 4;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  axi_req_t    req = '0;
  axi_rsp_t    rsp;
  logic [15:0] msw;
  logic [15:0] cw1;
  logic        ext;
  logic        inPos = 1'b1;
  logic        brake = 1'b1;
  logic        still = 1'b1;
  logic        rev = 1'b0;
  block_out_t  bo;
  logic        bs;
  logic        run;
  logic        dir;
  logic        alarm;
  logic        fault;
  logic [31:0] rd;
  logic [1:0]  rr;
  logic        seen;
  int          errors = 0;
  int          n_compared = 0;
  always #25 clk = ~clk;
  plc_controller_model plc_u (.clk(clk), .modeSelectWord(msw), .controlWord1(cw1),
    .extBlockChange(ext));
  traversing_block_sequencer #(.IPO_DIV(IPO)) dut_u (.clk(clk), .rst_b(rst_b), .axiIn(req),
    .axiOut(rsp), .modeSelectWord(msw), .controlWord1(cw1), .extBlockChange(ext),
    .brakingPoint(brake), .inPosWindow(inPos), .standstill(still), .reverseNeeded(rev),
    .blockOut(bo), .blockStart(bs), .seqRunning(run), .directMode(dir),
    .missingChangeAlarm(alarm), .stopFault(fault));
  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    n_compared++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    req.awaddr <= a;
    req.awvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.wvalid <= 1'b1;
    req.bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.awready && req.awvalid) req.awvalid <= 1'b0;
      if (rsp.wready && req.wvalid) req.wvalid <= 1'b0;
      if (rsp.bvalid && req.bready)
      begin
        rr = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    while (req.bready);
  endtask
  task automatic axr(input logic [11:0] a);
    @(posedge clk);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    req.rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (rsp.arready && req.arvalid) req.arvalid <= 1'b0;
      if (rsp.rvalid && req.rready)
      begin
        rd = rsp.rdata;
        rr = rsp.rresp;
        req.rready <= 1'b0;
      end
    end
    while (req.rready);
  endtask
  function automatic logic [11:0] ad(input logic [3:0] b, input logic [2:0] f);
    return {3'h0, b, f, 2'h0};
  endfunction
  function automatic logic [31:0] fv(input logic [3:0] b, input logic [2:0] f);
    return {16'hA500, 4'h0, b, 5'h00, f};
  endfunction
  function automatic logic [15:0] mw(input logic [3:0] t, input logic [3:0] c, input logic h);
    return {4'h0, t, c, 3'h0, h};
  endfunction
  task automatic prog(input logic [3:0] b, input logic [3:0] tc, input logic [15:0] md,
                      input logic [31:0] pa);
    axw(ad(b, F_TASK), {28'h0000000, tc});
    for (int f = 1; f < 5; f++) axw(ad(b, 3'(f)), fv(b, 3'(f)));
    axw(ad(b, F_PARAM), pa);
    axw(ad(b, F_MODE), {16'h0000, md});
  endtask
  // bounded so that a missing start is reported instead of hanging
  task automatic wait_start(input int lim);
    seen = 1'b0;
    repeat (lim)
    begin
      @(posedge clk);
      #1;
      if (bs === 1'b1) seen = 1'b1;
      if (seen) break;
    end
  endtask
  task automatic exp_blk(input logic [3:0] b, input logic [3:0] tc, input logic [2:0] pm,
                         input logic [31:0] pa);
    wait_start(3 * IPO);
    chk({31'h0, seen}, 32'h1, "no block start");
    chk({31'h0, run}, 32'h1, "not running");
    chk({28'h0, bo.number}, {28'h0, b}, "index");
    chk({28'h0, bo.taskCode}, {28'h0, tc}, "task code");
    chk({29'h0, bo.relative, bo.modPos, bo.modNeg}, {29'h0, pm}, "type");
    chk(bo.target, fv(b, F_TARGET), "target");
    chk(bo.velocity, fv(b, F_VEL), "velocity");
    chk(bo.accel, fv(b, F_ACCEL), "accel");
    chk(bo.decel, fv(b, F_DECEL), "decel");
    chk(bo.param, pa, "param");
  endtask
  task automatic reg_access();
    for (int t = 1; t < 10; t++)
    begin
      axw(ad(4'hF, F_TASK), 32'(t));
      axr(ad(4'hF, F_TASK));
      chk(rd, 32'(t), "task readback");
    end
    axw(ad(4'hF, F_MODE), 32'h00000351);
    axr(ad(4'hF, F_MODE));
    chk(rd, 32'h00000351, "mode readback");
    chk({30'h0, rr}, {30'h0, RESP_OKAY}, "read okay");
    axw(ad(4'h0, 3'h7), 32'h12345678);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR}, "write unmapped");
    axr(12'h208);
    chk({30'h0, rr}, {30'h0, RESP_SLVERR}, "read unmapped");
    chk(rd, 32'h00000000, "unmapped data");
  endtask
  task automatic chain_run();
    prog(4'h0, 4'h1, mw(4'h0, 4'h1, 1'b0), 32'h0);
    prog(4'h1, 4'h1, mw(4'h1, 4'h2, 1'b0), 32'h0);
    prog(4'h2, 4'h1, mw(4'h2, 4'h3, 1'b0), 32'h0);
    prog(4'h3, 4'h1, mw(4'h3, 4'h1, 1'b1), 32'h0);
    prog(4'h4, 4'h6, mw(4'h1, 4'h1, 1'b0), 32'h9);
    prog(4'h9, 4'h5, mw(4'h1, 4'h0, 1'b0), 32'h7);
    @(posedge clk) inPos <= 1'b0;
    plc_u.select(1'b0, 4'h0);
    plc_u.activate(1'b1);
    exp_blk(4'h0, 4'h1, 3'h0, 32'h0);
    wait_start(2 * IPO);
    chk({31'h0, seen}, 32'h0, "left before window");
    @(posedge clk) inPos <= 1'b1;
    rev <= 1'b1;
    exp_blk(4'h1, 4'h1, 3'h4, 32'h0);
    // a reversing successor must wait for the positioning window
    @(posedge clk) inPos <= 1'b0;
    wait_start(2 * IPO);
    chk({31'h0, seen}, 32'h0, "reversed on the fly");
    @(posedge clk) inPos <= 1'b1;
    rev <= 1'b0;
    exp_blk(4'h2, 4'h1, 3'h2, 32'h0);
    // braking point held off so only the external edge can move on
    @(posedge clk) brake <= 1'b0;
    wait_start(2 * IPO);
    chk({31'h0, seen}, 32'h0, "left before edge");
    plc_u.ext_change(1'b1);
    exp_blk(4'h3, 4'h1, 3'h1, 32'h0);
    chk({31'h0, bo.hidden}, 32'h1, "hide flag");
    plc_u.ext_change(1'b0);
    brake <= 1'b1;
    exp_blk(4'h4, 4'h6, 3'h0, 32'h9);
    exp_blk(4'h9, 4'h5, 3'h0, 32'h7);
    wait_start(2 * IPO);
    chk({31'h0, seen}, 32'h0, "ran past end");
    axr(STATUS_ADDR);
    chk({30'h0, rd[1:0]}, 32'h2, "state done");
    chk({28'h0, rd[11:8]}, 32'h9, "current index");
    plc_u.activate(1'b0);
    repeat (2 * IPO) @(posedge clk);
  endtask
  task automatic ext_wait_run();
    axw(CTRL_ADDR, 32'h00000001);
    prog(4'h6, 4'h1, mw(4'h0, 4'h4, 1'b0), 32'h0);
    prog(4'h7, 4'h1, mw(4'h0, 4'h5, 1'b0), 32'h0);
    plc_u.select(1'b0, 4'h6);
    plc_u.activate(1'b1);
    exp_blk(4'h6, 4'h1, 3'h0, 32'h0);
    wait_start(3 * IPO);
    chk({31'h0, seen}, 32'h0, "left without trigger");
    axw(ad(4'h6, F_TARGET), 32'h00000000);
    chk(bo.target, fv(4'h6, F_TARGET), "edit leaked");
    @(posedge clk) still <= 1'b0;
    plc_u.ext_change(1'b1);
    exp_blk(4'h7, 4'h1, 3'h0, 32'h0);
    chk({28'h0, bo.cont}, 32'h5, "continuation");
    repeat (2 * IPO) @(posedge clk);
    #1;
    chk({31'h0, alarm}, 32'h0, "alarm while moving");
    @(posedge clk) still <= 1'b1;
    repeat (2 * IPO) @(posedge clk);
    #1;
    chk({31'h0, alarm}, 32'h1, "alarm");
    chk({30'h0, fault, run}, 32'h2, "fault stop");
    plc_u.activate(1'b0);
    plc_u.ext_change(1'b0);
    repeat (2 * IPO) @(posedge clk);
    plc_u.activate(1'b1);
    wait_start(3 * IPO);
    chk({31'h0, seen}, 32'h0, "start while faulted");
    axw(STATUS_ADDR, 32'h0000000C);
    #1;
    chk({31'h0, fault}, 32'h0, "fault clear");
    chk({31'h0, alarm}, 32'h0, "alarm clear");
    plc_u.activate(1'b0);
  endtask
  task automatic direct_refused();
    plc_u.select(1'b1, 4'h0);
    repeat (2 * IPO) @(posedge clk);
    #1;
    chk({31'h0, dir}, 32'h1, "direct flag");
    plc_u.activate(1'b1);
    wait_start(3 * IPO);
    chk({31'h0, seen}, 32'h0, "start in direct");
    // a level that stays high must not restart the table
    plc_u.select(1'b0, 4'h2);
    wait_start(3 * IPO);
    chk({31'h0, seen}, 32'h0, "start without edge");
    plc_u.activate(1'b0);
    repeat (2 * IPO) @(posedge clk);
    plc_u.activate(1'b1);
    exp_blk(4'h2, 4'h1, 3'h2, 32'h0);
    plc_u.activate(1'b0);
    repeat (2 * IPO) @(posedge clk);
    #1;
    chk({31'h0, run}, 32'h0, "deactivate");
  endtask
  task automatic print_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    reg_access();
    chain_run();
    ext_wait_run();
    direct_refused();
    print_verdict();
  end
  initial
  begin
    #(20000 * 50);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule
